// ### logic/udc_datapath.sv
`timescale 1ns/100ps
// Operation
// - Saturate input symmetric when quarter-rate IF.
// - No internal saturation; carry integer growth.
// - Round filters and mixer half-to-even; output bit drop truncates.
// - Wrap two's-complement on overflow.
// - One headroom bit, then unity gain.
// - Carrier sum adds integer bits.
// - Carriers only on gcd raster step.
// - Frequencies are integer raster multiples.
// - Filter history untouched by reset.
// - Output valid four cycles after each input sample.
// - Flag marks unknown-history interval.
// - Quarter-rate IF shifts real input to zero.
// - Input 11..17, output 11..18 bits.
module udc_datapath
   import udc_pkg::*;
#(
   parameter int IN_W    = udc_pkg::IN_W_DEF,
   parameter int OUT_W   = udc_pkg::OUT_W_DEF,
   parameter int TAPS    = udc_pkg::NUM_TAPS_DEF,
   parameter int NUM_CAR = udc_pkg::NUM_CAR_DEF,
   parameter bit QIF_EN  = 1'b1
) (
   input  wire logic                                   CLK,
   input  wire logic                                   RST,
   input  wire logic                                   IN_VALID,
   input  wire logic [IN_W-1:0]                        IN_DATA,
   input  wire logic [NUM_CAR*udc_pkg::FREQ_IDX_W-1:0] CARRIER_FREQ_IDX,
   output logic                                        OUT_VALID,
   output logic [OUT_W-1:0]                            OUT_I,
   output logic [OUT_W-1:0]                            OUT_Q,
   output logic                                        OUT_HISTORY_UNKNOWN_FLAG
);

   // ------------------------------------------------------------------
   // Widths.
   // ------------------------------------------------------------------
   localparam int CAR_BITS = $clog2(NUM_CAR);          // Mixer sum growth.
   localparam int W1       = IN_W + HEADROOM_BITS;     // After headroom bit.
   localparam int WM       = W1 + CAR_BITS + 1;        // After carrier mixing.
   localparam int LATENCY  = 2 * TAPS;                 // Samples to flush.
   localparam int CNT_W    = $clog2(LATENCY + 1);
   // Low bits dropped at the output; the kept top bits carry all integer growth.
   localparam int OUT_SHIFT = (WM > OUT_W) ? WM - OUT_W : 0;

   localparam logic [IN_W-1:0] IN_MAX = {1'b0, {(IN_W-1){1'b1}}};  // +0.999.
   localparam logic [IN_W-1:0] IN_MIN = {1'b1, {(IN_W-2){1'b0}}, 1'b1}; // -0.999.
   localparam logic [IN_W-1:0] IN_NEG = {1'b1, {(IN_W-1){1'b0}}};  // -1.0.

   // ------------------------------------------------------------------
   // Input synchroniser stage and saturation.
   // ------------------------------------------------------------------
   logic [IN_W-1:0] sat_q;     // Saturated input sample.
   logic            sat_vld_q; // Strobe for it.

   // Clamp -1.0 to -0.999 first so the inversion step below stays symmetric.
   always_ff @(posedge CLK) begin
      if (QIF_EN && IN_DATA == IN_NEG) begin
         sat_q <= IN_MIN;
      end else begin
         sat_q <= IN_DATA;
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         sat_vld_q <= 1'b0;
      end else begin
         sat_vld_q <= IN_VALID;
      end
   end

   // ------------------------------------------------------------------
   // Quarter-rate IF translation: multiply by 1, -j, -1, +j in turn.
   // ------------------------------------------------------------------
   logic [1:0]      qphase_q;  // Position in the quarter-rate cycle.
   logic [W1-1:0]   bb_i_q;    // Baseband in-phase, with headroom bit.
   logic [W1-1:0]   bb_q_q;    // Baseband quadrature, with headroom bit.
   logic            bb_vld_q;  // Strobe for the baseband pair.
   logic [W1-1:0]   ext;       // Sign-extended saturated sample.

   // Sign extension adds the single headroom bit at the start of the chain.
   assign ext = W1'($signed(sat_q));

   // The rotation restarts at reset so every run sees the same phase order.
   always_ff @(posedge CLK) begin
      if (RST) begin
         qphase_q <= 2'h0;
      end else if (sat_vld_q) begin
         qphase_q <= qphase_q + 2'h1;
      end
   end

   // Inversion of the saturated sample needs no extra integer bit.
   always_ff @(posedge CLK) begin
      if (sat_vld_q) begin
         if (!QIF_EN) begin
            bb_i_q <= ext;
            bb_q_q <= '0;
         end else begin
            case (qphase_q)
               2'h0: begin
                  bb_i_q <= ext;
                  bb_q_q <= '0;
               end
               2'h1: begin
                  bb_i_q <= '0;
                  bb_q_q <= W1'(-ext);
               end
               2'h2: begin
                  bb_i_q <= W1'(-ext);
                  bb_q_q <= '0;
               end
               default: begin
                  bb_i_q <= '0;
                  bb_q_q <= ext;
               end
            endcase
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (RST) begin
         bb_vld_q <= 1'b0;
      end else begin
         bb_vld_q <= sat_vld_q;
      end
   end

   // ------------------------------------------------------------------
   // Channel filters, one per rail, history persists over reset.
   // ------------------------------------------------------------------
   udc_stage_if #(.W(W1)) fi_in ();
   udc_stage_if #(.W(W1)) fi_out ();
   udc_stage_if #(.W(W1)) fq_in ();
   udc_stage_if #(.W(W1)) fq_out ();

   assign fi_in.vld = bb_vld_q;
   assign fi_in.dat = bb_i_q;
   assign fq_in.vld = bb_vld_q;
   assign fq_in.dat = bb_q_q;

   udc_fir_stage #(.W(W1), .TAPS(TAPS)) u_fir_i (
      .CLK  (CLK),
      .RST  (RST),
      .din  (fi_in),
      .dout (fi_out)
   );

   udc_fir_stage #(.W(W1), .TAPS(TAPS)) u_fir_q (
      .CLK  (CLK),
      .RST  (RST),
      .din  (fq_in),
      .dout (fq_out)
   );

   // ------------------------------------------------------------------
   // Rasterized carrier mixer: each carrier advances its phase by a
   // whole number of raster steps per sample.
   // ------------------------------------------------------------------
   logic [PHASE_W-1:0]  phase_q [NUM_CAR];  // Per-carrier phase.
   logic [PHASE_W-1:0]  incr    [NUM_CAR];  // Per-carrier increment.
   logic signed [COEF_W-1:0] cos_v [NUM_CAR]; // Table cosine.
   logic signed [COEF_W-1:0] sin_v [NUM_CAR]; // Table sine.

   // Quarter-wave-free 16-entry sine table in Q1.15.
   function automatic logic signed [COEF_W-1:0] sine_lut(input logic [LUT_ADDR_W-1:0] a);
      case (a)
         4'h0: return 16'sh0000;
         4'h1: return 16'sh30FC;
         4'h2: return 16'sh5A82;
         4'h3: return 16'sh7642;
         4'h4: return 16'sh7FFF;
         4'h5: return 16'sh7642;
         4'h6: return 16'sh5A82;
         4'h7: return 16'sh30FC;
         4'h8: return 16'sh0000;
         4'h9: return 16'shCF04;
         4'hA: return 16'shA57E;
         4'hB: return 16'sh89BE;
         4'hC: return 16'sh8001;
         4'hD: return 16'sh89BE;
         4'hE: return 16'shA57E;
         default: return 16'shCF04;
      endcase
   endfunction

   generate
      for (genvar c = 0; c < NUM_CAR; c++) begin : g_car
         // Index counts raster steps; reduced modulo the raster points.
         logic [FREQ_IDX_W-1:0] idx;
         assign idx = CARRIER_FREQ_IDX[c*FREQ_IDX_W +: FREQ_IDX_W];
         // Phase step = idx * 2^PHASE_W / RASTER_POINTS, an exact multiple.
         assign incr[c] = PHASE_W'((64'(idx) % 64'(RASTER_POINTS)) * (64'(1) << PHASE_W)
                                   / 64'(RASTER_POINTS));
         always_ff @(posedge CLK) begin
            if (RST) begin
               phase_q[c] <= '0;
            end else if (fi_out.vld) begin
               phase_q[c] <= phase_q[c] + incr[c];
            end
         end
         assign sin_v[c] = sine_lut(phase_q[c][PHASE_W-1 -: LUT_ADDR_W]);
         assign cos_v[c] = sine_lut(LUT_ADDR_W'(phase_q[c][PHASE_W-1 -: LUT_ADDR_W] + 4'h4));
      end
   endgenerate

   // Complex multiply per carrier, convergent round, then combined sum.
   localparam int PW = W1 + COEF_W + 1;
   logic [WM-1:0] sum_i;  // Combined in-phase, widened by carrier bits.
   logic [WM-1:0] sum_q;  // Combined quadrature.

   function automatic logic [WM-1:0] conv_rnd(input logic [PW-1:0] p);
      logic [PW-1:0] half;
      logic [PW-1:0] r;
      half = PW'(1) << (COEF_FRAC - 1);
      if (p[COEF_FRAC-1:0] == half[COEF_FRAC-1:0] && !p[COEF_FRAC]) begin
         r = p;
      end else begin
         r = p + half;
      end
      return WM'($signed(r[PW-1:COEF_FRAC]));
   endfunction

   always_comb begin
      logic [PW-1:0] pi;
      logic [PW-1:0] pq;
      // Products start cleared so that nothing is held over between passes.
      pi    = '0;
      pq    = '0;
      sum_i = '0;
      sum_q = '0;
      for (int c = 0; c < NUM_CAR; c++) begin
         pi = PW'($signed(fi_out.dat) * cos_v[c] - $signed(fq_out.dat) * sin_v[c]);
         pq = PW'($signed(fi_out.dat) * sin_v[c] + $signed(fq_out.dat) * cos_v[c]);
         sum_i = sum_i + conv_rnd(pi);
         sum_q = sum_q + conv_rnd(pq);
      end
   end

   // ------------------------------------------------------------------
   // Output register; dropping the low bits truncates rather than rounds.
   // ------------------------------------------------------------------
   logic            out_vld_q;
   logic [OUT_W-1:0] out_i_q;
   logic [OUT_W-1:0] out_q_q;

   always_ff @(posedge CLK) begin
      if (RST) begin
         out_vld_q <= 1'b0;
      end else begin
         out_vld_q <= fi_out.vld;
      end
   end

   // Rails are cleared by reset so that a fresh run starts from zero.
   always_ff @(posedge CLK) begin
      if (RST) begin
         out_i_q <= '0;
         out_q_q <= '0;
      end else if (fi_out.vld) begin
         out_i_q <= OUT_W'($signed(sum_i) >>> OUT_SHIFT);
         out_q_q <= OUT_W'($signed(sum_q) >>> OUT_SHIFT);
      end
   end

   // ------------------------------------------------------------------
   // History-unknown flag: held until a full latency of samples passes.
   // ------------------------------------------------------------------
   udc_flush_t       flush_q;   // Flushing or settled.
   logic [CNT_W-1:0] flush_cnt_q; // Samples accepted since reset.

   always_ff @(posedge CLK) begin
      if (RST) begin
         flush_q     <= UDC_FLUSHING;
         flush_cnt_q <= '0;
      end else begin
         case (flush_q)
            UDC_FLUSHING: begin
               if (IN_VALID) begin
                  if (flush_cnt_q == CNT_W'(LATENCY - 1)) begin
                     flush_q <= UDC_SETTLED;
                  end
                  flush_cnt_q <= flush_cnt_q + CNT_W'(1);
               end
            end
            default: flush_q <= UDC_SETTLED;
         endcase
      end
   end

   // Outputs come straight from registers; the flag is a state decode and never glitches.
   assign OUT_VALID                = out_vld_q;
   assign OUT_I                    = out_i_q;
   assign OUT_Q                    = out_q_q;
   assign OUT_HISTORY_UNKNOWN_FLAG = (flush_q == UDC_FLUSHING);

endmodule

// ### logic/udc_pkg.sv
package udc_pkg;

   // ------------------------------------------------------------------
   // Numeric format constants.
   // ------------------------------------------------------------------
   localparam int IN_W_DEF      = 16;   // Default input word width (11..17).
   localparam int OUT_W_DEF     = 18;   // Default output word width (11..18).
   localparam int IN_W_MIN      = 11;   // Smallest input width allowed.
   localparam int IN_W_MAX      = 17;   // Largest input width allowed.
   localparam int OUT_W_MIN     = 11;   // Smallest output width allowed.
   localparam int OUT_W_MAX     = 18;   // Largest output width allowed.
   localparam int HEADROOM_BITS = 1;    // Extra integer bit at chain start.
   localparam int NUM_TAPS_DEF  = 8;    // Taps of each filter stage.
   localparam int NUM_CAR_DEF   = 2;    // Carriers combined by the mixer.
   localparam int COEF_W        = 16;   // Coefficient width.
   localparam int COEF_FRAC     = 15;   // Fraction bits of coefficients.
   localparam int PHASE_W       = 16;   // Width of the mixer phase accumulator.
   localparam int LUT_ADDR_W    = 4;    // Phase bits used to address sine table.

   // ------------------------------------------------------------------
   // Frequency raster constants.
   // ------------------------------------------------------------------
   localparam longint AIR_RASTER_HZ = 100_000;    // Air-standard raster, 100 kHz.
   localparam longint MIX_RATE_HZ   = 6_400_000;  // Mixer sample rate in Hz.
   localparam int     FREQ_IDX_W    = 16;         // Width of raster-index words.

   // Greatest common divisor, used for the mixer raster step.
   function automatic longint udc_gcd(input longint a, input longint b);
      longint x;
      longint y;
      longint t;
      x = a;
      y = b;
      while (y != 0) begin
         t = x % y;
         x = y;
         y = t;
      end
      return x;
   endfunction

   localparam longint RASTER_STEP_HZ = udc_gcd(AIR_RASTER_HZ, MIX_RATE_HZ);
   localparam longint RASTER_POINTS  = MIX_RATE_HZ / RASTER_STEP_HZ;

   // ------------------------------------------------------------------
   // Flush state machine.
   // ------------------------------------------------------------------
   typedef enum logic [0:0] {
      UDC_FLUSHING,
      UDC_SETTLED
   } udc_flush_t;

endpackage

// ### logic/udc_stage_if.sv
`timescale 1ns/100ps
// Link between the top module and a filter stage: one sample and its strobe.
interface udc_stage_if #(parameter int W = 18);
   logic         vld;    // Sample strobe.
   logic [W-1:0] dat;    // Two's-complement sample.
   modport src (output vld, output dat);
   modport dst (input vld, input dat);
endinterface

// ### logic/udc_fir_stage.sv
`timescale 1ns/100ps
// One FIR stage whose history is never reset, with convergent rounding
// and wrapping output.
module udc_fir_stage
   import udc_pkg::*;
#(
   parameter int W    = 18,
   parameter int TAPS = udc_pkg::NUM_TAPS_DEF
) (
   input  wire logic                  CLK,
   input  wire logic                  RST,
   udc_stage_if.dst                   din,
   udc_stage_if.src                   dout
);

   // ------------------------------------------------------------------
   // Storage.
   // ------------------------------------------------------------------
   localparam int ACC_W = W + COEF_W + $clog2(TAPS) + 1;  // Full accumulator.

   logic [W-1:0]     hist_q [TAPS];  // Sample history, never cleared.
   logic [ACC_W-1:0] acc;            // Full-precision sum of products.
   logic [ACC_W-1:0] rnd;            // Convergently rounded sum.
   logic             vld_q;          // Output strobe.
   logic [W-1:0]     dat_q;          // Output sample.

   // Unity-gain averaging coefficient per tap.
   localparam logic signed [COEF_W-1:0] COEF = COEF_W'((1 << COEF_FRAC) / TAPS);

   // ------------------------------------------------------------------
   // History shift: no reset term at all, so reset leaves it untouched.
   // ------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (din.vld) begin
         hist_q[0] <= din.dat;
         for (int i = 1; i < TAPS; i++) begin
            hist_q[i] <= hist_q[i-1];
         end
      end
   end

   // ------------------------------------------------------------------
   // Multiply-accumulate with round-half-to-even.
   // ------------------------------------------------------------------
   always_comb begin
      logic [ACC_W-1:0] half;
      logic             tie;
      half = '0;
      tie  = 1'b0;
      acc = '0;
      for (int i = 0; i < TAPS; i++) begin
         acc = acc + ACC_W'($signed(hist_q[i]) * COEF);
      end
      half = ACC_W'(1) << (COEF_FRAC - 1);
      tie  = (acc[COEF_FRAC-1:0] == half[COEF_FRAC-1:0]);
      // Ties go to the even neighbour, others to nearest.
      if (tie && !acc[COEF_FRAC]) begin
         rnd = acc;
      end else begin
         rnd = acc + half;
      end
   end

   // ------------------------------------------------------------------
   // Output register; truncating to W bits wraps on overflow.
   // ------------------------------------------------------------------
   always_ff @(posedge CLK) begin
      if (RST) begin
         vld_q <= 1'b0;
      end else begin
         vld_q <= din.vld;
      end
   end

   always_ff @(posedge CLK) begin
      if (din.vld) begin
         dat_q <= rnd[COEF_FRAC +: W];
      end
   end

   assign dout.vld = vld_q;
   assign dout.dat = dat_q;

endmodule

// ### bench/udc_datapath_monitor.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Port checker for the converter datapath.
// ------------------------------------------------------------------
module udc_datapath_monitor #(
   parameter int OUT_W = 18,
   parameter int TAPS  = 8
) (
   input wire logic             CLK,
   input wire logic             RST,
   input wire logic             IN_VALID,
   input wire logic             OUT_VALID,
   input wire logic [OUT_W-1:0] OUT_I,
   input wire logic [OUT_W-1:0] OUT_Q,
   input wire logic             OUT_HISTORY_UNKNOWN_FLAG
);
   localparam logic [7:0] FLUSH = 8'(2 * TAPS); // Samples that flush the history.
   logic [7:0]            acc_cnt_q;            // Samples taken since reset, saturating.

   // Counts accepted samples so that the flag release can be timed.
   always_ff @(posedge CLK) begin
      if (RST) begin
         acc_cnt_q <= 8'h00;
      end else if (IN_VALID && (acc_cnt_q < FLUSH)) begin
         acc_cnt_q <= acc_cnt_q + 8'h01;
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   property p_reset_quiet;
      disable iff (1'b0) RST |=> !OUT_VALID && OUT_HISTORY_UNKNOWN_FLAG && (OUT_I == '0) && (OUT_Q == '0);
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("outputs not at reset values");
   property p_flag_held;
      (acc_cnt_q < FLUSH) |-> OUT_HISTORY_UNKNOWN_FLAG;
   endproperty
   a_flag_held: assert property (p_flag_held) else $error("flag low before flush done");
   property p_flag_released;
      (acc_cnt_q >= FLUSH) |-> !OUT_HISTORY_UNKNOWN_FLAG;
   endproperty
   a_flag_released: assert property (p_flag_released) else $error("flag high after flush");
   property p_flag_no_rise;
      !OUT_HISTORY_UNKNOWN_FLAG |=> !OUT_HISTORY_UNKNOWN_FLAG;
   endproperty
   a_flag_no_rise: assert property (p_flag_no_rise) else $error("flag rose without reset");
   property p_answer_bound;
      IN_VALID |-> ##[4:5] OUT_VALID;
   endproperty
   a_answer_bound: assert property (p_answer_bound) else $error("sample produced no output");
   property p_no_orphan;
      !IN_VALID [*6] |-> !OUT_VALID;
   endproperty
   a_no_orphan: assert property (p_no_orphan) else $error("output strobe without input");
   property p_rails_hold;
      !OUT_VALID |-> $stable(OUT_I) && $stable(OUT_Q);
   endproperty
   a_rails_hold: assert property (p_rails_hold) else $error("rails moved without strobe");
   property p_quiet_after_release;
      $fell(RST) |-> !OUT_VALID [*4];
   endproperty
   a_quiet_after_release: assert property (p_quiet_after_release) else $error("early strobe");
endmodule

bind udc_datapath udc_datapath_monitor #(.OUT_W(OUT_W), .TAPS(TAPS)) u_monitor (
   .CLK(CLK), .RST(RST), .IN_VALID(IN_VALID), .OUT_VALID(OUT_VALID), .OUT_I(OUT_I),
   .OUT_Q(OUT_Q), .OUT_HISTORY_UNKNOWN_FLAG(OUT_HISTORY_UNKNOWN_FLAG));

// ### bench/udc_bb_source.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Baseband sample source standing in front of the datapath.
// ------------------------------------------------------------------
module udc_bb_source
   import udc_pkg::*;
#(
   parameter int IN_W    = 16,
   parameter int NUM_CAR = 2
) (
   input  wire logic                                   clk,
   output logic                                        in_valid,
   output logic [IN_W-1:0]                             in_data,
   output logic [NUM_CAR*udc_pkg::FREQ_IDX_W-1:0]      freq_idx
);
   // Idle values at time zero.
   initial begin
      in_valid = 1'b0;
      in_data  = '0;
      freq_idx = '0;
   end

   // Presents one sample after a rising edge; it is taken at the next edge.
   task automatic send(input logic [IN_W-1:0] v);
      @(posedge clk);
      in_valid <= 1'b1;
      in_data  <= v;
   endtask

   // Drops the strobe and scrambles the idle data so stale values are not trusted.
   task automatic rest();
      @(posedge clk);
      in_valid <= 1'b0;
      in_data  <= ~in_data;
   endtask

   // Sets every carrier to one raster index; callers keep it near zero hertz.
   task automatic tune(input logic [FREQ_IDX_W-1:0] idx);
      @(posedge clk);
      for (int c = 0; c < NUM_CAR; c++) begin
         freq_idx[c*FREQ_IDX_W +: FREQ_IDX_W] <= idx;
      end
   endtask
endmodule

// ### bench/udc_datapath_tb.sv
`timescale 1ns/100ps
// ------------------------------------------------------------------
// Self-checking bench for the converter datapath.
// ------------------------------------------------------------------
module udc_datapath_tb;
   import udc_pkg::*;
   localparam int IW = IN_W_DEF;     // Input width under test.
   localparam int OW = OUT_W_DEF;    // Output width under test.
   localparam int NT = NUM_TAPS_DEF; // Taps per stage.
   localparam int NC = NUM_CAR_DEF;  // Carriers.
   logic                   clk;      // Bench clock, 40 ns.
   logic                   rst;      // Synchronous reset.
   logic                   iv;       // Input strobe from the source.
   logic [IW-1:0]          id;       // Input sample.
   logic [NC*FREQ_IDX_W-1:0] fi;     // Carrier indices.
   logic                   ov;       // Output strobe.
   logic [OW-1:0]          oi, oq;   // Output rails.
   logic                   flg;      // History-unknown flag.
   int                     bad_count, checks, out_cnt;
   logic                   got_first;
   logic [OW-1:0]          first_i, first_q, last_i, last_q, save_i, save_q;

   // Clock generation.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   udc_bb_source #(.IN_W(IW), .NUM_CAR(NC)) src (.clk(clk), .in_valid(iv), .in_data(id), .freq_idx(fi));
   udc_datapath #(.IN_W(IW), .OUT_W(OW), .TAPS(NT), .NUM_CAR(NC), .QIF_EN(1'b1)) dut (
      .CLK(clk), .RST(rst), .IN_VALID(iv), .IN_DATA(id), .CARRIER_FREQ_IDX(fi),
      .OUT_VALID(ov), .OUT_I(oi), .OUT_Q(oq), .OUT_HISTORY_UNKNOWN_FLAG(flg));

   // Records the first and last output of each run.
   always @(posedge clk) begin
      if (!rst && ov === 1'b1) begin
         out_cnt++;
         last_i = oi;
         last_q = oq;
         if (!got_first) begin
            first_i   = oi;
            first_q   = oq;
            got_first = 1'b1;
         end
      end
   end

   // ------------------------------------------------------------------
   // Shared helpers.
   // ------------------------------------------------------------------
   task automatic report_and_stop();
      $display("checks=%0d mismatches=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic check_eq(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic do_reset(input int n);
      src.rest();
      rst <= 1'b1;
      repeat (n) @(posedge clk);
      rst       <= 1'b0;
      got_first = 1'b0;
      out_cnt   = 0;
   endtask

   // Sends n samples of the pattern v0, 0, v2, 0 and waits for all outputs.
   task automatic feed(input logic [IW-1:0] v0, input logic [IW-1:0] v2, input int n);
      int base;
      base = out_cnt;
      for (int k = 0; k < n; k++) begin
         src.send((k % 4 == 0) ? v0 : ((k % 4 == 2) ? v2 : '0));
      end
      src.rest();
      for (int i = 0; i < 60 && out_cnt < base + n; i++) begin
         @(posedge clk);
      end
      if (out_cnt < base + n) begin
         bad_count++;
         report_and_stop();
      end
      @(negedge clk);
   endtask

   // ------------------------------------------------------------------
   // Scenarios.
   // ------------------------------------------------------------------
   task automatic t_flag();
      do_reset(2);
      repeat (2 * NT - 1) src.send(16'h0100);
      src.rest();
      @(negedge clk);
      check_eq(32'(flg), 32'h1);
      src.send(16'h0100);
      src.rest();
      @(negedge clk);
      check_eq(32'(flg), 32'h0);
      $display("test flag done");
   endtask

   task automatic t_zero();
      do_reset(2);
      feed(16'h0000, 16'h0000, 3 * NT);
      check_eq(32'(last_i), 32'h0);
      check_eq(32'(last_q), 32'h0);
      $display("test zero done");
   endtask

   task automatic t_sat();
      do_reset(2);
      feed(16'h8000, 16'h7FFF, 3 * NT);
      save_i = last_i;
      save_q = last_q;
      do_reset(2);
      feed(16'h8001, 16'h7FFF, 3 * NT);
      check_eq(32'(last_i), 32'(save_i));
      check_eq(32'(last_q), 32'(save_q));
      $display("test saturation done");
   endtask

   task automatic t_raster();
      do_reset(2);
      src.tune(16'h0000);
      feed(16'h4000, 16'hC000, 3 * NT);
      save_i = last_i;
      save_q = last_q;
      // Two unit carriers at zero hertz double the 0x2000 filter mean; the kept top bits halve it.
      check_eq(32'(save_i), 32'h00002000);
      check_eq(32'(save_q), 32'h00000000);
      do_reset(2);
      src.tune(16'(RASTER_POINTS));
      feed(16'h4000, 16'hC000, 3 * NT);
      check_eq(32'(last_i), 32'(save_i));
      check_eq(32'(last_q), 32'(save_q));
      $display("test raster done");
   endtask

   task automatic t_history();
      do_reset(2);
      feed(16'h4000, 16'hC000, 3 * NT);
      do_reset(2);
      feed(16'h0000, 16'h0000, 3 * NT);
      check_eq(32'((first_i | first_q) != '0), 32'h1);
      check_eq(32'(last_i | last_q), 32'h0);
      $display("test history done");
   endtask

   // Main sequence.
   initial begin
      rst       = 1'b1;
      bad_count = 0;
      checks    = 0;
      out_cnt   = 0;
      got_first = 1'b0;
      do_reset(20);
      t_flag();
      t_zero();
      t_sat();
      t_raster();
      t_history();
      report_and_stop();
   end
endmodule
